// ---- pwm_output_control_fault_trigger.sv ----
// Output override, polarity, fault handling and event trigger of a
// three-pair PWM generator, with an AXI4-Lite register slave.
// Assumes the time base, duty comparators and dead-time units sit outside
// on aclk and feed count, period, matches and dead-time shaped levels.
//
// Notes on behaviour
// - Time base mode 10 selects single-pulse; only edge-aligned outputs then.
// - Single-pulse: enabled high and independent low pins go active on run set, inactive on duty match.
// - Single-pulse period match: clear counter, pins inactive, stop run, irq.
// - Six override selects upper half, six values lower; selected pins forced.
// - Complementary pair: low overridden active becomes complement of high.
// - No dead-time is inserted on complementary pairs under override.
// - With sync set, overrides apply at zero, or zero/period in center modes.
// - At reset pins drive inactive if strap is 0, float if strap is 1.
// - High polarity bit sets all high-side levels, low bit all low-side.
// - Each pin has an enable; disabled pins are released to GPIO.
// - Three per-pair fault enables; all clear leaves the pins alone, flag still sets.
// - Six fault-state bits: clear drives inactive, set active, per polarity.
// - Complementary pair with both fault states active: high pin wins.
// - Latched fault holds until pin high and flag cleared, then boundary.
// - Cycle mode holds only while pin low, resumes at next boundary.
// - One fault-mode bit picks latched or cycle-by-cycle handling.
// - Update lockout set blocks loading buffered duty and period values.
// - Event trigger fires when the count equals the event compare value.
// - Up/down modes: phase bit clear fires counting up, set counting down.
// - Event triggers pass a postscaler 1:1 to 1:16 set by four bits.
// - Event postscaler count cleared on compare write and on reset.
// - During sleep a low fault pin raises a wake interrupt.
// - Edge-aligned: active at count zero, inactive at duty match.
// - Count top bit gives direction: 0 counting up, 1 counting down.
`default_nettype none

module pwm_output_control_fault_trigger
	import pwm_ofc_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [15:0] time_base_count,
	input  wire logic [14:0] period_value,
	input  wire logic        period_match,
	input  wire logic [2:0]  duty_match,
	input  wire logic [2:0]  dt_high,
	input  wire logic [2:0]  dt_low,
	input  wire logic        sleep_mode,
	input  wire logic        fault_input,
	input  wire logic        reset_pin_state_sel,
	input  wire logic        high_side_polarity,
	input  wire logic        low_side_polarity,
	output logic [2:0]       high_side_output,
	output logic [2:0]       high_side_oe,
	output logic [2:0]       low_side_output,
	output logic [2:0]       low_side_oe,
	output logic             time_base_run,
	output logic [1:0]       time_base_mode_sel,
	output logic             time_base_clear,
	output logic             update_enable,
	output logic             event_trigger,
	output logic             single_pulse_irq,
	output logic             fault_irq,
	output logic             fault_wake_irq
);

	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [15:0] wd, input logic [1:0] strb);
		merge16 = {strb[1] ? wd[15:8] : old[15:8],
			strb[0] ? wd[7:0] : old[7:0]};
	endfunction

	// ----------------------------------------------------------------
	// Register bus slave
	// ----------------------------------------------------------------
	logic        awready_ff, bvalid_ff, arready_ff, rvalid_ff;
	logic [1:0]  bresp_ff, rresp_ff;
	logic [31:0] rdata_ff;
	logic [1:0]  mode_ff;
	logic        run_ff, run_d_ff;
	logic [15:0] evt_cmp_ff, out_cfg_ff, upd_cfg_ff, flt_ctrl_ff, ovd_ff;
	logic        flag_ff;
	logic [1:0]  flt_sync_ff;
	logic        fault_low_d_ff;

	wire        wr_en   = awready_ff & s_axi_awvalid & s_axi_wvalid;
	wire [9:0]  wr_idx  = s_axi_awaddr[11:2];
	wire [9:0]  rd_idx  = s_axi_araddr[11:2];
	wire        rd_en   = arready_ff & s_axi_arvalid;
	wire [15:0] wd      = s_axi_wdata[15:0];
	wire [1:0]  ws      = s_axi_wstrb[1:0];
	wire        wr_tbc  = wr_en & (wr_idx == IDX_TB_CTRL);
	wire        wr_evt  = wr_en & (wr_idx == IDX_EVT_CMP) & (|ws);
	wire        wr_stat = wr_en & (wr_idx == IDX_STATUS) & ws[0];
	wire        fault_low = ~flt_sync_ff[1];

	function automatic logic known(input logic [9:0] i);
		known = (i == IDX_TB_CTRL) | (i == IDX_EVT_CMP) |
			(i == IDX_OUT_CFG) | (i == IDX_UPD_CFG) |
			(i == IDX_FLT_CTRL) | (i == IDX_OVD_CTRL) |
			(i == IDX_STATUS);
	endfunction

	logic [15:0] rd_mux;
	always_comb begin
		case (rd_idx)
			IDX_TB_CTRL:  rd_mux = {run_ff, 13'h0000, mode_ff};
			IDX_EVT_CMP:  rd_mux = evt_cmp_ff;
			IDX_OUT_CFG:  rd_mux = out_cfg_ff;
			IDX_UPD_CFG:  rd_mux = upd_cfg_ff;
			IDX_FLT_CTRL: rd_mux = flt_ctrl_ff;
			IDX_OVD_CTRL: rd_mux = ovd_ff;
			IDX_STATUS:   rd_mux = {14'h0000, fault_low, flag_ff};
			default:      rd_mux = 16'h0000;
		endcase
	end

	// Address and data are taken together; one write and one read in flight
	wire nxt_awready = s_axi_awvalid & s_axi_wvalid & ~awready_ff & ~bvalid_ff;
	wire nxt_arready = s_axi_arvalid & ~arready_ff & ~rvalid_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_ff <= 1'b0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= RESP_OKAY;
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b0;
			rresp_ff   <= RESP_OKAY;
			rdata_ff   <= 32'h0000_0000;
		end else begin
			awready_ff <= nxt_awready;
			arready_ff <= nxt_arready;
			if (wr_en) begin
				bvalid_ff <= 1'b1;
				bresp_ff  <= known(wr_idx) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready)
				bvalid_ff <= 1'b0;
			if (rd_en) begin
				rvalid_ff <= 1'b1;
				rdata_ff  <= {16'h0000, rd_mux};
				rresp_ff  <= known(rd_idx) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rready)
				rvalid_ff <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	wire       sp_mode = (mode_ff == TB_SINGLE);
	wire       center  = mode_ff[0];
	wire       sp_end  = sp_mode & run_ff & period_match;
	wire       run_rise = run_ff & ~run_d_ff;
	wire [15:0] tbc_wr = merge16({run_ff, 13'h0000, mode_ff}, wd, ws);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_ff     <= RST_MODE;
			run_ff      <= 1'b0;
			run_d_ff    <= 1'b0;
			evt_cmp_ff  <= RST_EVT_CMP;
			// Pin enables start from the strap so float stays float
			out_cfg_ff  <= {13'h0000, 3'h0} |
				{9'h000, {3{~reset_pin_state_sel}}, 1'b0,
				{3{~reset_pin_state_sel}}};
			upd_cfg_ff  <= RST_UPD_CFG;
			flt_ctrl_ff <= RST_FLT_CTRL;
			ovd_ff      <= RST_OVD_CTRL;
		end else begin
			run_d_ff <= run_ff;
			if (wr_tbc) begin
				mode_ff <= tbc_wr[MODE_LSB +: 2];
				run_ff  <= tbc_wr[RUN_BIT];
			end else if (sp_end)
				run_ff <= 1'b0;
			if (wr_en && wr_idx == IDX_EVT_CMP)
				evt_cmp_ff <= merge16(evt_cmp_ff, wd, ws);
			if (wr_en && wr_idx == IDX_OUT_CFG)
				out_cfg_ff <= merge16(out_cfg_ff, wd, ws) & 16'h0777;
			if (wr_en && wr_idx == IDX_UPD_CFG)
				upd_cfg_ff <= merge16(upd_cfg_ff, wd, ws) & 16'h0f03;
			if (wr_en && wr_idx == IDX_FLT_CTRL)
				flt_ctrl_ff <= merge16(flt_ctrl_ff, wd, ws) & 16'h3f87;
			if (wr_en && wr_idx == IDX_OVD_CTRL)
				ovd_ff <= merge16(ovd_ff, wd, ws) & 16'h3f3f;
		end
	end

	// ----------------------------------------------------------------
	// Fault input
	// ----------------------------------------------------------------
	wire [2:0] fen    = flt_ctrl_ff[FEN_LSB +: 3];
	wire       any_en = |fen;
	wire       latched = ~flt_ctrl_ff[FMODE_BIT];
	wire       fault_fall = fault_low & ~fault_low_d_ff;
	wire [14:0] cnt   = time_base_count[14:0];
	wire       cnt_dir = time_base_count[15];
	wire       at_zero = (cnt == 15'h0000);
	wire       bnd    = at_zero | (center & (cnt == period_value));
	logic      fault_active_ff;
	wire       release_ok = ~fault_low & bnd & (~latched | ~flag_ff);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flt_sync_ff     <= 2'h3;
			fault_low_d_ff  <= 1'b0;
			flag_ff         <= 1'b0;
			fault_active_ff <= 1'b0;
		end else begin
			flt_sync_ff    <= {flt_sync_ff[0], fault_input};
			fault_low_d_ff <= fault_low;
			// A new fault edge wins over a software clear
			if (fault_fall)
				flag_ff <= 1'b1;
			else if (wr_stat && wd[STAT_FLAG_BIT])
				flag_ff <= 1'b0;
			if (fault_low && any_en)
				fault_active_ff <= 1'b1;
			else if (release_ok)
				fault_active_ff <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Output path per pair
	// ----------------------------------------------------------------
	logic [15:0] ovd_eff_ff;
	logic [2:0]  pwm_state_ff;
	logic [2:0]  act_h_w, act_l_w, use_f_w;
	wire  [2:0]  indep = out_cfg_ff[INDEP_LSB +: 3];
	wire  [2:0]  pen_h = out_cfg_ff[PEN_H_LSB +: 3];
	wire  [2:0]  pen_l = out_cfg_ff[PEN_L_LSB +: 3];
	wire         override_sync = upd_cfg_ff[OVERRIDE_SYNC_BIT];

	always_ff @(posedge aclk) begin
		if (!aresetn)
			ovd_eff_ff <= RST_OVD_CTRL;
		else if (!override_sync || bnd)
			ovd_eff_ff <= ovd_ff;
	end

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_pair
			wire st_set = run_ff & ((mode_ff == TB_FREE & at_zero) |
				(sp_mode & run_rise));
			wire st_clr = duty_match[g] | (sp_mode & period_match);
			always_ff @(posedge aclk) begin
				if (!aresetn)
					pwm_state_ff[g] <= 1'b0;
				else if (st_clr)
					pwm_state_ff[g] <= 1'b0;
				else if (st_set)
					pwm_state_ff[g] <= 1'b1;
			end
			wire st    = pwm_state_ff[g];
			wire cmp_h = center ? dt_high[g] : st;
			wire cmp_l = center ? dt_low[g] :
				(indep[g] ? st : (~st & run_ff & ~sp_mode));
			wire sel_h = ovd_eff_ff[OVD_SEL_LSB + 2*g + 1];
			wire sel_l = ovd_eff_ff[OVD_SEL_LSB + 2*g];
			wire val_h = ovd_eff_ff[OVD_VAL_LSB + 2*g + 1];
			wire val_l = ovd_eff_ff[OVD_VAL_LSB + 2*g];
			wire ov_h  = sel_h ? val_h : cmp_h;
			// Complemented low tracks the high after its own override, ov_h
			wire ov_l  = sel_l ? ((~indep[g] & val_l) ? ~ov_h : val_l)
				: cmp_l;
			wire fs_h  = flt_ctrl_ff[FSTATE_LSB + 2*g + 1];
			wire fs_l  = flt_ctrl_ff[FSTATE_LSB + 2*g];
			assign use_f_w[g] = fault_active_ff & fen[g];
			assign act_h_w[g] = use_f_w[g] ? fs_h : ov_h;
			assign act_l_w[g] = use_f_w[g] ?
				(fs_l & (indep[g] | ~fs_h)) : ov_l;
		end
	endgenerate

	logic [2:0] hs_out_ff, hs_oe_ff, ls_out_ff, ls_oe_ff;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hs_out_ff <= {3{~high_side_polarity}};
			ls_out_ff <= {3{~low_side_polarity}};
			hs_oe_ff  <= {3{~reset_pin_state_sel}};
			ls_oe_ff  <= {3{~reset_pin_state_sel}};
		end else begin
			hs_out_ff <= act_h_w ~^ {3{high_side_polarity}};
			ls_out_ff <= act_l_w ~^ {3{low_side_polarity}};
			hs_oe_ff  <= pen_h;
			ls_oe_ff  <= pen_l;
		end
	end

	// ----------------------------------------------------------------
	// Event trigger, lockout and interrupts
	// ----------------------------------------------------------------
	logic [3:0] ev_cnt_ff;
	logic       ev_trig_ff, tb_clr_ff, sp_irq_ff, upd_en_ff, wake_ff;
	wire  [3:0] post_sel = upd_cfg_ff[POST_LSB +: 4];
	wire        ev_match = run_ff & (cnt == evt_cmp_ff[14:0]) &
		(~center | (cnt_dir == evt_cmp_ff[EVT_DIR_BIT]));
	wire        ev_fire  = ev_match & (ev_cnt_ff == post_sel);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ev_cnt_ff  <= 4'h0;
			ev_trig_ff <= 1'b0;
			tb_clr_ff  <= 1'b0;
			sp_irq_ff  <= 1'b0;
			upd_en_ff  <= 1'b0;
			wake_ff    <= 1'b0;
		end else begin
			if (wr_evt)
				ev_cnt_ff <= 4'h0;
			else if (ev_fire)
				ev_cnt_ff <= 4'h0;
			else if (ev_match)
				ev_cnt_ff <= ev_cnt_ff + 4'h1;
			ev_trig_ff <= ev_fire & ~wr_evt;
			tb_clr_ff  <= sp_end;
			sp_irq_ff  <= sp_end;
			upd_en_ff  <= ~upd_cfg_ff[UPDATE_LOCKOUT_BIT];
			wake_ff    <= sleep_mode & fault_low;
		end
	end

	assign s_axi_awready      = awready_ff;
	assign s_axi_wready       = awready_ff;
	assign s_axi_bvalid       = bvalid_ff;
	assign s_axi_bresp        = bresp_ff;
	assign s_axi_arready      = arready_ff;
	assign s_axi_rvalid       = rvalid_ff;
	assign s_axi_rdata        = rdata_ff;
	assign s_axi_rresp        = rresp_ff;
	assign high_side_output   = hs_out_ff;
	assign high_side_oe       = hs_oe_ff;
	assign low_side_output    = ls_out_ff;
	assign low_side_oe        = ls_oe_ff;
	assign time_base_run      = run_ff;
	assign time_base_mode_sel = mode_ff;
	assign time_base_clear    = tb_clr_ff;
	assign update_enable      = upd_en_ff;
	assign event_trigger      = ev_trig_ff;
	assign single_pulse_irq   = sp_irq_ff;
	assign fault_irq          = flag_ff;
	assign fault_wake_irq     = wake_ff;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sp_start_a: assert property (sp_mode && run_rise && duty_match == 3'h0
		&& !period_match |=> pwm_state_ff == 3'h7)
		else $error("single pulse did not start");
	sp_end_a: assert property (sp_end && !wr_tbc |=>
		!run_ff && single_pulse_irq && time_base_clear ##1 !time_base_clear)
		else $error("single pulse end sequence wrong");
	ovd_sync_a: assert property (override_sync && !bnd |=> $stable(ovd_eff_ff))
		else $error("override changed off boundary");
	ovd_async_a: assert property (!override_sync |=> ovd_eff_ff == $past(ovd_ff))
		else $error("override not applied next clock");
	fault_gate_a: assert property ($rose(fault_active_ff) |-> $past(any_en))
		else $error("fault acted with no pair enabled");
	fault_prio_a: assert property ((use_f_w & ~indep & act_h_w & act_l_w)
		== 3'h0) else $error("both pins active under fault");
	latch_hold_a: assert property (fault_active_ff && latched && flag_ff
		|=> fault_active_ff) else $error("latched fault released");
	cbc_hold_a: assert property (fault_low && any_en |=> fault_active_ff)
		else $error("fault not held while pin low");
	post_clr_a: assert property (wr_evt |=> ev_cnt_ff == 4'h0 && !event_trigger)
		else $error("postscaler not cleared on compare write");
	evt_src_a: assert property (event_trigger |-> $past(ev_match))
		else $error("event trigger without compare match");
	lockout_a: assert property (upd_cfg_ff[UPDATE_LOCKOUT_BIT] |=> !update_enable)
		else $error("updates allowed during lockout");
	pin_rel_a: assert property ((hs_oe_ff & ~$past(pen_h)) == 3'h0)
		else $error("disabled pin still driven");
	pol_a: assert property (high_side_output ==
		($past(act_h_w) ~^ {3{$past(high_side_polarity)}}))
		else $error("high side polarity wrong");
	wake_a: assert property (sleep_mode && fault_low |=> fault_wake_irq)
		else $error("no wake on fault during sleep");

	sp_run_c:    cover property (sp_end ##1 !run_ff);
	fault_rel_c: cover property ($fell(fault_active_ff) && latched);
	evt_fire_c:  cover property (event_trigger && post_sel != 4'h0);

endmodule // pwm_output_control_fault_trigger

`default_nettype wire

// ---- pwm_ofc_pkg.sv ----
// Constants for the PWM output control, fault and event trigger block.
// Assumes a 32-bit AXI4-Lite register bus with 12 address bits.
`default_nettype none

package pwm_ofc_pkg;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [9:0] IDX_TB_CTRL   = 10'h1c0;
	localparam logic [9:0] IDX_EVT_CMP   = 10'h1c6;
	localparam logic [9:0] IDX_OUT_CFG   = 10'h1c8;
	localparam logic [9:0] IDX_UPD_CFG   = 10'h1ca;
	localparam logic [9:0] IDX_FLT_CTRL  = 10'h1d0;
	localparam logic [9:0] IDX_OVD_CTRL  = 10'h1d4;
	localparam logic [9:0] IDX_STATUS    = 10'h1e0;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int RUN_BIT       = 15;
	localparam int MODE_LSB      = 0;
	localparam int EVT_DIR_BIT   = 15;
	localparam int INDEP_LSB     = 8;
	localparam int PEN_H_LSB     = 4;
	localparam int PEN_L_LSB     = 0;
	localparam int POST_LSB      = 8;
	localparam int OVERRIDE_SYNC_BIT     = 1;
	localparam int UPDATE_LOCKOUT_BIT      = 0;
	localparam int FSTATE_LSB    = 8;
	localparam int FMODE_BIT     = 7;
	localparam int FEN_LSB       = 0;
	localparam int OVD_SEL_LSB   = 8;
	localparam int OVD_VAL_LSB   = 0;
	localparam int STAT_FLAG_BIT = 0;
	localparam int STAT_PIN_BIT  = 1;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] RST_EVT_CMP  = 16'h0000;
	localparam logic [15:0] RST_UPD_CFG  = 16'h0000;
	localparam logic [15:0] RST_FLT_CTRL = 16'h0000;
	localparam logic [15:0] RST_OVD_CTRL = 16'h3f00;
	localparam logic [1:0]  RST_MODE     = 2'h0;

	// ----------------------------------------------------------------
	// Time base modes and bus answers
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		TB_FREE   = 2'h0,
		TB_UPDN   = 2'h1,
		TB_SINGLE = 2'h2,
		TB_UPDN2  = 2'h3
	} tb_mode_e;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

`default_nettype wire

// ---- pwm_far_side_model.sv ----
// Far side of the PWM block: gate drivers and an external fault detector.
// Assumes pin levels and enables come straight from the block's outputs.
`default_nettype none

module pwm_far_side_model (
	input  wire logic [2:0] high_out,
	input  wire logic [2:0] high_oe,
	input  wire logic [2:0] low_out,
	input  wire logic [2:0] low_oe,
	input  wire logic       fault_req,
	output logic [2:0]      high_pin,
	output logic [2:0]      low_pin,
	output logic            fault_n
);
	// Gate inputs have pull-downs, so a released pin never keeps its level
	assign high_pin = high_out & high_oe;
	assign low_pin  = low_out & low_oe;
	// Open-drain detector with pull-up: low while a fault is reported
	assign fault_n  = ~fault_req;
endmodule // pwm_far_side_model

`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the PWM output control, fault and event block.
// Assumes the package, the design and the far-side model compile first.
`default_nettype none

module testbench import pwm_ofc_pkg::*; ();
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [11:0] OVD = {IDX_OVD_CTRL, 2'b00};
	localparam logic [11:0] FLT = {IDX_FLT_CTRL, 2'b00};
	localparam logic [11:0] UPD = {IDX_UPD_CFG, 2'b00};
	localparam logic [11:0] EVT = {IDX_EVT_CMP, 2'b00};
	localparam logic [11:0] TBC = {IDX_TB_CTRL, 2'b00};
	localparam logic [11:0] OCF = {IDX_OUT_CFG, 2'b00};
	localparam logic [11:0] STA = {IDX_STATUS, 2'b00};
	localparam logic [11:0] RA [5] = '{OVD, FLT, UPD, EVT, 12'h7fc};
	localparam logic [33:0] RV [5] = '{34'h3f00, 34'h0, 34'h0, 34'h0,
		{RESP_SLVERR, 32'h0}};
	logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, period_match;
	logic        sleep_mode, fault_input, reset_pin_state_sel, fault_req;
	logic        high_side_polarity, low_side_polarity, time_base_run;
	logic        time_base_clear, update_enable, event_trigger, noisy;
	logic        single_pulse_irq, fault_irq, fault_wake_irq;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [1:0]  s_axi_bresp, s_axi_rresp, time_base_mode_sel, resp;
	logic [2:0]  s_axi_awprot, s_axi_arprot, duty_match, dt_high, dt_low;
	logic [2:0]  high_side_output, high_side_oe, low_side_output;
	logic [2:0]  low_side_oe, hpin, lpin, dm;
	logic [3:0]  s_axi_wstrb;
	logic [14:0] period_value;
	logic [15:0] time_base_count;
	logic [5:0]  v, s, pins, oe, outs;
	integer      seed, n_errors, num_checks, cycles, n_evt, n_sp, e0, p, c;
	assign pins = {hpin, lpin};
	assign oe   = {high_side_oe, low_side_oe};
	assign outs = {high_side_output, low_side_output};

	pwm_output_control_fault_trigger uut (.*);
	pwm_far_side_model far (.high_out(high_side_output),
		.high_oe(high_side_oe), .low_out(low_side_output),
		.low_oe(low_side_oe), .fault_req(fault_req), .high_pin(hpin),
		.low_pin(lpin), .fault_n(fault_input));

	// ------------------------------------------------------------
	// Clock, timeout, noise and tasks
	// ------------------------------------------------------------
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		n_evt <= n_evt + (event_trigger === 1'b1);
		n_sp <= n_sp + (single_pulse_irq === 1'b1);
		dt_high <= 3'($random(seed));
		dt_low <= 3'($random(seed));
		duty_match <= noisy ? 3'($random(seed)) : dm;
		if (cycles == 20000) begin
			$display("[FAIL] %0t timeout", $time);
			n_errors = n_errors + 1;
			tally_and_finish();
		end
	end
	// Expected pin levels for six active-level bits, high pair bit first
	function automatic logic [5:0] lvl(input logic [5:0] a);
		for (int g = 0; g < 3; g++) begin
			lvl[g + 3] = a[2 * g + 1] ~^ high_side_polarity;
			lvl[g] = a[2 * g] ~^ low_side_polarity;
		end
	endfunction
	task automatic chk(input logic [33:0] got, input logic [33:0] exp,
		input string what);
		num_checks = num_checks + 1;
		if (got !== exp) begin
			n_errors = n_errors + 1;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			aw_ok = aw_ok | (s_axi_awready === 1'b1);
			w_ok = w_ok | (s_axi_wready === 1'b1);
			s_axi_awvalid <= !aw_ok;
			s_axi_wvalid <= !w_ok;
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd_reg(input logic [11:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// Alternate the count between the compare value and one past it
	task automatic match(input int n);
		repeat (n) begin
			@(posedge aclk);
			time_base_count <= c[15:0];
			@(posedge aclk);
			time_base_count <= c[15:0] + 16'h0001;
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		seed = 32'h8d8b2409;
		{n_errors, num_checks, cycles, n_evt, n_sp} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
		{s_axi_rready, period_match, sleep_mode, fault_req, noisy} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot} = '0;
		{s_axi_arprot, dm} = '0;
		{high_side_polarity, low_side_polarity} = 2'($random(seed));
		s_axi_wstrb = 4'hf;
		period_value = 15'($random(seed));
		time_base_count = 16'h0005;
		reset_pin_state_sel = 1'b1;
		aresetn = 1'b0;
		cyc(10);
		chk({oe, outs}, {6'h00, lvl(6'h00)}, "float at reset");
		aresetn <= 1'b1;
		cyc(2);
		aresetn <= 1'b0;
		reset_pin_state_sel <= 1'b0;
		cyc(3);
		chk({oe, outs}, {6'h3f, lvl(6'h00)}, "drive at reset");
		aresetn <= 1'b1;
		foreach (RA[i]) begin
			rd_reg(RA[i]);
			chk({resp, rd}, RV[i], "reset value");
		end
		wr(OCF, 16'h0705);
		cyc(2);
		chk(oe, 6'h05, "pin enables");
		wr(OCF, 16'h0777);
		$display("reset and register test done");
		v = 6'h00;
		repeat (6) begin
			v = 6'($random(seed));
			wr(OVD, 16'h3f00 | v);
			cyc(2);
			chk(pins, lvl(v), "override");
		end
		wr(UPD, 16'h0002);
		s = 6'($random(seed));
		wr(OVD, 16'h3f00 | s);
		cyc(3);
		chk(pins, lvl(v), "sync wait");
		time_base_count <= 16'h0000;
		cyc(3);
		chk(pins, lvl(s), "sync apply");
		time_base_count <= 16'h0005;
		v = s;
		wr(UPD, 16'h0000);
		$display("override test done");
		wr(FLT, 16'h3f00);
		sleep_mode <= 1'b1;
		fault_req <= 1'b1;
		cyc(6);
		chk({pins, fault_wake_irq}, {lvl(v), 1'b1}, "no pair");
		fault_req <= 1'b0;
		sleep_mode <= 1'b0;
		for (int m = 0; m < 2; m++) begin
			s = 6'($random(seed));
			wr(STA, 16'h0001);
			wr(FLT, {2'b00, s, m[0], 7'h07});
			fault_req <= 1'b1;
			cyc(6);
			chk({pins, fault_irq}, {lvl(s), 1'b1}, "fault");
			fault_req <= 1'b0;
			cyc(6);
			chk(pins, lvl(s), "held");
			time_base_count <= 16'h0000;
			cyc(3);
			chk(pins, m ? lvl(v) : lvl(s), "boundary");
			wr(STA, 16'h0001);
			cyc(2);
			chk({pins, fault_irq}, {lvl(v), 1'b0}, "flag clear");
			time_base_count <= 16'h0005;
		end
		$display("fault test done");
		wr(OVD, 16'h0000);
		noisy <= 1'b0;
		dm <= 3'h0;
		wr(TBC, 16'h8002);
		cyc(3);
		chk({time_base_mode_sel, pins}, {2'h2, lvl(6'h3f)}, "one shot");
		dm <= 3'h2;
		cyc(1);
		dm <= 3'h0;
		cyc(3);
		chk(pins, lvl(6'h33), "duty end");
		e0 = n_sp;
		period_match <= 1'b1;
		cyc(1);
		period_match <= 1'b0;
		cyc(1);
		chk(time_base_clear, 1'b1, "counter clear");
		cyc(2);
		chk({time_base_run, pins}, {1'b0, lvl(6'h00)}, "period end");
		chk(n_sp - e0, 1, "one shot irq");
		noisy <= 1'b1;
		$display("single pulse test done");
		wr(TBC, 16'h8000);
		for (int i = 0; i < 3; i++) begin
			p = i == 0 ? 0 : i == 1 ? 15 : 1 + {$random(seed)} % 14;
			c = $random(seed) & 32'h3fff;
			wr(UPD, {4'h0, p[3:0], 8'h01});
			cyc(2);
			chk(update_enable, 1'b0, "lockout");
			wr(EVT, c[15:0]);
			e0 = n_evt;
			match(2 * (p + 1));
			cyc(3);
			chk(n_evt - e0, 2, "postscale");
			if (p > 0) begin
				match(p);
				wr(EVT, c[15:0]);
				match(p);
				cyc(3);
				chk(n_evt - e0, 2, "postscale clear");
			end
		end
		wr(UPD, 16'h0000);
		cyc(2);
		chk(update_enable, 1'b1, "unlock");
		wr(TBC, 16'h8001);
		wr(EVT, 16'h8123);
		for (int d = 0; d < 2; d++) begin
			c = d * 32'h8000 + 32'h0123;
			e0 = n_evt;
			match(2);
			cyc(3);
			chk(n_evt - e0, 2 * d, "event phase");
		end
		$display("event trigger test done");
		wr(OCF, 16'h0077);
		for (int k = 0; k < 2; k++) begin
			wr(OVD, k ? 16'h3f3f : 16'h3f15);
			cyc(2);
			chk(pins, lvl(k ? 6'h2a : 6'h15), "complement");
		end
		wr(FLT, 16'h3f87);
		fault_req <= 1'b1;
		cyc(6);
		chk(pins, lvl(6'h2a), "high priority");
		fault_req <= 1'b0;
		$display("complement test done");
		tally_and_finish();
	end
endmodule // testbench

`default_nettype wire
